// ---- irq_flag_cfg.svh ----
`ifndef IRQ_FLAG_CFG_SVH
`define IRQ_FLAG_CFG_SVH
// register byte offsets
`define OFS_FLAG0       4'h0
`define OFS_FLAG1       4'h4
`define OFS_MASK0       4'h8
`define OFS_MASK1       4'hc
// flag register 0 bit positions
`define B0_EXT_IRQ0     0
`define B0_ICAP_CH1     1
`define B0_OCMP_CH1     2
// flag register 1 bit positions
`define B1_I2C_SLAVE    0
`define B1_I2C_MASTER   1
`define B1_ANALOG_CMP1  2
`define B1_PIN_CHANGE   3
`define B1_EXT_IRQ1     4
`define B1_XFER_CH2     8
`define B1_OCMP_CH3     9
`define B1_OCMP_CH4     10
`define B1_TIMER_FOUR   11
`define B1_TIMER_FIVE   12
`define B1_EXT_IRQ2     13
`define B1_UART_B_RX    14
`define B1_UART_B_TX    15
// implemented bit masks and reset values
`define IMPL0_MASK      16'h0007
`define IMPL1_MASK      16'hff1f
`define FLAG_RST        16'h0000
`define MASK_RST        16'h0000
`define RDATA_UNMAPPED  32'h0000_0000
`endif

// ---- irq_flag_pkg.sv ----
package irq_flag_pkg;
	// one strobe per peripheral event source
	typedef struct packed {
		logic uart_b_tx;
		logic uart_b_rx;
		logic ext_irq2;
		logic timer_five;
		logic timer_four;
		logic ocmp_ch4;
		logic ocmp_ch3;
		logic xfer_ch2_done;
		logic ext_irq1;
		logic pin_change;
		logic analog_cmp1;
		logic i2c_a_master;
		logic i2c_a_slave;
		logic ocmp_ch1;
		logic icap_ch1;
		logic ext_irq0;
	} event_type;
endpackage

// ---- interrupt_flag_status_bank.sv ----
// Local design decisions: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`include "irq_flag_cfg.svh"
// Overview of operation
// [R1] flag 0 bit 2 latches output compare channel 1 requests
// [R2] flag 0 bit 1 latches input capture channel 1 requests
// [R3] flag 0 bit 0 latches external interrupt 0 requests
// [R4] flag 1 bits 15 and 14 hold second uart transmit and receive
// [R5] second uart receive event sets its own separate bit
// [R6] flag 1 bit 13 latches external interrupt 2 requests
// [R7] flag 1 bit 12 latches timer five requests
// [R8] flag 1 bit 11 latches timer four requests
// [R9] flag 1 bits 10 and 9 latch compare channels 4 and 3
// [R10] flag 1 bit 8 latches transfer channel 2 completion
// [R11] flag 1 bits 7 to 5 ignore writes, read zero
// [R12] bits 4,3,2 latch external irq 1, pin change, comparator 1
// [R13] bits 1 and 0 latch i2c master and slave events
// [R14] flags reset zero; event or written one sets, written zero clears
// [R15] event beats same-cycle clear; software clears before re-enabling
module interrupt_flag_status_bank (
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire logic                      clk_en,
	input  wire irq_flag_pkg::event_type   events,
	input  wire logic [3:0]                avs_address,
	input  wire logic                      avs_read,
	input  wire logic                      avs_write,
	input  wire logic [31:0]               avs_writedata,
	input  wire logic [3:0]                avs_byteenable,
	output logic      [31:0]               avs_readdata,
	output logic                           avs_waitrequest,
	output logic                           irq
);
	logic [15:0] flag0_q;
	logic [15:0] flag1_q;
	logic [15:0] flag0_d;
	logic [15:0] flag1_d;
	logic [15:0] mask0_q;
	logic [15:0] mask1_q;
	logic [15:0] ev0;
	logic [15:0] ev1;
	logic        ack_q;
	logic        wr_go;
	logic        rd_go;
	logic [15:0] wmask;

	// merge two byte lanes into a 16-bit field update
	function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
		input logic [15:0] new_v, input logic [1:0] be);
		logic [15:0] r;
		r = old_v;
		if (be[0]) begin
			r[7:0] = new_v[7:0];
		end
		if (be[1]) begin
			r[15:8] = new_v[15:8];
		end
		return r;
	endfunction

	// event strobes placed at their flag positions
	always_comb begin
		ev0 = 16'h0000;
		ev0[`B0_OCMP_CH1]    = events.ocmp_ch1; // R1
		ev0[`B0_ICAP_CH1]    = events.icap_ch1; // R2
		ev0[`B0_EXT_IRQ0]    = events.ext_irq0; // R3
		ev1 = 16'h0000;
		ev1[`B1_UART_B_TX]   = events.uart_b_tx; // R4
		ev1[`B1_UART_B_RX]   = events.uart_b_rx; // R5
		ev1[`B1_EXT_IRQ2]    = events.ext_irq2; // R6
		ev1[`B1_TIMER_FIVE]  = events.timer_five; // R7
		ev1[`B1_TIMER_FOUR]  = events.timer_four; // R8
		ev1[`B1_OCMP_CH4]    = events.ocmp_ch4; // R9
		ev1[`B1_OCMP_CH3]    = events.ocmp_ch3; // R9
		ev1[`B1_XFER_CH2]    = events.xfer_ch2_done; // R10
		ev1[`B1_EXT_IRQ1]    = events.ext_irq1; // R12
		ev1[`B1_PIN_CHANGE]  = events.pin_change; // R12
		ev1[`B1_ANALOG_CMP1] = events.analog_cmp1; // R12
		ev1[`B1_I2C_MASTER]  = events.i2c_a_master; // R13
		ev1[`B1_I2C_SLAVE]   = events.i2c_a_slave; // R13
	end

	// one wait cycle per access; a write lands in the ack cycle only,
	// where the master sees waitrequest low, so it lands exactly once
	assign wr_go = avs_write & ack_q;
	assign rd_go = avs_read & ~ack_q;
	assign wmask = lane_merge(16'h0000, 16'hffff, avs_byteenable[1:0]);

	// software write value, then events ored on top so the set wins
	always_comb begin
		flag0_d = flag0_q;
		flag1_d = flag1_q;
		if (wr_go && avs_address == `OFS_FLAG0) begin
			flag0_d = lane_merge(flag0_q, avs_writedata[15:0],
				avs_byteenable[1:0]); // R14
		end
		if (wr_go && avs_address == `OFS_FLAG1) begin
			flag1_d = lane_merge(flag1_q, avs_writedata[15:0],
				avs_byteenable[1:0]); // R14
		end
		flag0_d = (flag0_d | ev0) & `IMPL0_MASK; // R15
		flag1_d = (flag1_d | ev1) & `IMPL1_MASK; // R11 R15
	end

	// flag storage
	always_ff @(posedge clk) begin
		if (rst) begin
			flag0_q <= `FLAG_RST; // R14
			flag1_q <= `FLAG_RST; // R14
		end else if (clk_en) begin
			flag0_q <= flag0_d;
			flag1_q <= flag1_d;
		end
	end

	// mask registers, same layout as the flags
	always_ff @(posedge clk) begin
		if (rst) begin
			mask0_q <= `MASK_RST;
			mask1_q <= `MASK_RST;
		end else if (clk_en && wr_go) begin
			if (avs_address == `OFS_MASK0) begin
				mask0_q <= lane_merge(mask0_q, avs_writedata[15:0],
					avs_byteenable[1:0]) & `IMPL0_MASK;
			end
			if (avs_address == `OFS_MASK1) begin
				mask1_q <= lane_merge(mask1_q, avs_writedata[15:0],
					avs_byteenable[1:0]) & `IMPL1_MASK;
			end
		end
	end

	// bus handshake; waitrequest low exactly in the ack cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			ack_q           <= 1'b0;
			avs_waitrequest <= 1'b1;
		end else if (clk_en) begin
			ack_q           <= (avs_read | avs_write) & ~ack_q;
			avs_waitrequest <= ~((avs_read | avs_write) & ~ack_q);
		end
	end

	// read data captured with the ack; unmapped reads give zero
	always_ff @(posedge clk) begin
		if (rst) begin
			avs_readdata <= `RDATA_UNMAPPED;
		end else if (clk_en && rd_go) begin
			case (avs_address)
				`OFS_FLAG0: avs_readdata <= {16'h0000, flag0_q};
				`OFS_FLAG1: avs_readdata <= {16'h0000, flag1_q}; // R11
				`OFS_MASK0: avs_readdata <= {16'h0000, mask0_q};
				`OFS_MASK1: avs_readdata <= {16'h0000, mask1_q};
				default:    avs_readdata <= `RDATA_UNMAPPED;
			endcase
		end
	end

	// level interrupt from next-state flags; changes on the same edge as a flag
	always_ff @(posedge clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else if (clk_en) begin
			irq <= |((flag0_d & mask0_q) | (flag1_d & mask1_q));
		end
	end

	logic unused_ok;
	assign unused_ok = ^{wmask, avs_writedata[31:16], avs_byteenable[3:2]};
endmodule

// ---- irq_flag_chk.sv ----
`timescale 1ns/1ps
module irq_flag_chk (
	input wire logic                    clk,
	input wire logic                    rst,
	input wire logic                    clk_en,
	input wire irq_flag_pkg::event_type events,
	input wire logic                    avs_read,
	input wire logic                    avs_write,
	input wire logic [31:0]             avs_readdata,
	input wire logic                    avs_waitrequest,
	input wire logic                    irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// bus handshake: one wait cycle, one ack cycle
	property p_one; !avs_waitrequest && clk_en |=> avs_waitrequest; endproperty
	a_one: assert property (p_one) else $error("ack too long");
	property p_lat;
		(avs_read || avs_write) && avs_waitrequest && clk_en |=> !avs_waitrequest;
	endproperty
	a_lat: assert property (p_lat) else $error("ack late");
	property p_why; $fell(avs_waitrequest) |-> $past(avs_read || avs_write); endproperty
	a_why: assert property (p_why) else $error("ack unasked");
	property p_top; avs_readdata[31:16] == 16'h0000; endproperty
	a_top: assert property (p_top) else $error("upper half set");
	property p_hold; !$fell(avs_waitrequest) |-> $stable(avs_readdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	// irq moves only on an event or an acked write
	property p_rise;
		$rose(irq) |-> $past(|events)
			|| $past(avs_write && !avs_waitrequest, 2)
			|| $past(!clk_en, 2);
	endproperty
	a_rise: assert property (p_rise) else $error("irq rose alone");
	// a mask write reaches irq one edge after a flag write does
	property p_fall;
		$fell(irq) |-> $past(avs_write && !avs_waitrequest)
			|| $past(avs_write && !avs_waitrequest, 2)
			|| $past(!clk_en, 2);
	endproperty
	a_fall: assert property (p_fall) else $error("irq fell alone");
	property p_frz; !clk_en |=> $stable(irq) && $stable(avs_waitrequest); endproperty
	a_frz: assert property (p_frz) else $error("state moved frozen");
	c_irq: cover property ($rose(irq));
	c_rd: cover property (avs_read && !avs_waitrequest);
	c_wr: cover property (avs_write && !avs_waitrequest);
endmodule

// ---- irq_event_src.sv ----
`timescale 1ns/1ps
// peripheral sources; registered so strobes leave just after an edge
module irq_event_src (
	input  wire logic [15:0]        fire,
	input  wire logic               clk,
	output irq_flag_pkg::event_type events
);
	// a level on fire models a source that keeps requesting
	always_ff @(posedge clk) begin
		events <= fire;
	end
endmodule

// ---- test_interrupt_flag_status_bank.sv ----
`timescale 1ns/1ps
`include "irq_flag_cfg.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_interrupt_flag_status_bank;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        en = 1'b1;
	logic [15:0] fire = 16'h0000;
	logic [3:0]  adr = 4'h0;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wd = 32'h0000_0000;
	logic [3:0]  be = 4'hf;
	logic [31:0] rdata;
	logic        wreq;
	logic        irq;
	logic [15:0] got;
	logic [31:0] ex;
	int          bad_count = 0;
	int          tests_run = 0;
	int          cyc = 0;
	irq_flag_pkg::event_type ev;
	initial forever #10 clk = ~clk;
	irq_event_src irq_event_src_i (.clk(clk), .fire(fire), .events(ev));
	interrupt_flag_status_bank interrupt_flag_status_bank_i (.clk(clk),
		.rst(rst), .clk_en(en), .events(ev), .avs_address(adr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
		.avs_readdata(rdata), .avs_waitrequest(wreq), .irq(irq));
	task automatic final_report();
		$display("mismatches %0d of %0d", bad_count, tests_run);
		if (bad_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// holds the request until waitrequest is seen low
	task automatic bus(logic w, logic [3:0] a, logic [15:0] d, logic [3:0] b);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		wd <= {16'h0000, d};
		be <= b;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		if (n >= 20) bad_count++;
		got = rdata[15:0];
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic rdc(logic [3:0] a, logic [15:0] e);
		bus(1'b0, a, 16'h0000, 4'hf);
		`CHK("rd", e, got)
	endtask
	task automatic irqc(logic e);
		@(posedge clk);
		@(negedge clk);
		`CHK("irq", e, irq)
	endtask
	// low three sources land in flag 0, the rest in flag 1
	function automatic logic [31:0] emap(int k);
		if (k < 3) return {16'h0000, 16'h0001 << k};
		if (k < 8) return {16'h0001 << (k - 3), 16'h0000};
		return {16'h0001 << k, 16'h0000};
	endfunction
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc > 3000) begin
			bad_count++;
			final_report();
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 4; i++) rdc(4'(i * 4), 16'h0000);
		rdc(4'h2, 16'h0000);
		$display("reset test done");
		for (int k = 0; k < 16; k++) begin
			@(posedge clk);
			fire <= 16'h0001 << k;
			@(posedge clk);
			fire <= 16'h0000;
			ex = emap(k);
			rdc(`OFS_FLAG0, ex[15:0]);
			rdc(`OFS_FLAG1, ex[31:16]);
			bus(1'b1, `OFS_FLAG0, 16'h0000, 4'hf);
			bus(1'b1, `OFS_FLAG1, 16'h0000, 4'hf);
		end
		rdc(`OFS_FLAG1, 16'h0000);
		$display("source test done");
		bus(1'b1, `OFS_FLAG0, 16'hffff, 4'hf);
		rdc(`OFS_FLAG0, 16'h0007);
		bus(1'b1, `OFS_FLAG1, 16'hffff, 4'hf);
		rdc(`OFS_FLAG1, 16'hff1f);
		bus(1'b1, `OFS_FLAG1, 16'h0000, 4'h1);
		rdc(`OFS_FLAG1, 16'hff00);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rdc(`OFS_FLAG1, 16'h0000);
		$display("write test done");
		bus(1'b1, `OFS_MASK1, 16'h0001, 4'hf);
		fire <= 16'h0008;
		@(posedge clk);
		fire <= 16'h0000;
		irqc(1'b1);
		bus(1'b1, `OFS_MASK1, 16'h0000, 4'hf);
		irqc(1'b0);
		bus(1'b1, `OFS_MASK1, 16'h0001, 4'hf);
		en <= 1'b0;
		repeat (3) @(posedge clk);
		en <= 1'b1;
		irqc(1'b1);
		@(posedge clk);
		fire <= 16'h0008;
		bus(1'b1, `OFS_FLAG1, 16'h0000, 4'hf);
		rdc(`OFS_FLAG1, 16'h0001);
		fire <= 16'h0000;
		bus(1'b1, `OFS_FLAG1, 16'h0000, 4'hf);
		irqc(1'b0);
		$display("irq test done");
		final_report();
	end
endmodule
bind interrupt_flag_status_bank irq_flag_chk irq_flag_chk_i (.clk, .rst,
	.clk_en, .events, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
	.irq);
